// ---- pkg/fsr_pkg.sv ----
// package for the flash operation status register block
package fsr_pkg;
    // status byte bit positions
    localparam int BIT_IDLE        = 7;
    localparam int BIT_ERASE_PAUSE = 6;
    localparam int BIT_ERASE_FAIL  = 5;
    localparam int BIT_PROG_FAIL   = 4;
    localparam int BIT_SUPPLY      = 3;
    localparam int BIT_PROG_PAUSE  = 2;
    localparam int BIT_PROT_FAIL   = 1;
    localparam int BIT_BANK        = 0;
    // reset value: idle, no error
    localparam logic [7:0]  STATUS_RESET = 8'h80;
    localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
    localparam int DATA_W = 16;
    localparam int BANK_W = 4;
    // erase suspend latency, in ns, and in cycles of a 100 ns clock
    localparam int CLK_NS            = 100;
    localparam int ERASE_SUSP_LAT_NS = 25000;
    localparam int ERASE_SUSP_CYC    = ERASE_SUSP_LAT_NS / CLK_NS;
    localparam int PROG_SUSP_LAT_NS  = 25000;
    localparam int PROG_SUSP_CYC     = PROG_SUSP_LAT_NS / CLK_NS;
endpackage

// ---- src/fsr_status.sv ----
// flash operation status register with pin-side snapshot logic
//
// Behaviour
// - snapshot taken on chip or output enable fall, held until it rises
// - during program or erase, bank reads return status unless array mode
// - idle, suspend and bank bits are set and cleared by device itself
// - error bits stay set until clear-status command or hardware reset
// - idle bit is 0 while controller busy, 1 when idle
// - after suspend, idle bit stays 0 until controller paused or suspend latency elapsed
// - erase paused bit set within latency; erase done first skips suspend
// - resume clears erase paused bit and continues the erase
// - erase fail set when max pulses applied and block still fails verify
// - blank check sets erase fail when any word differs from all ones
// - new erase appears to fail while erase fail bit set
// - program fail set when max pulses applied and word fails verify
// - programming a one over a zero flags only at supply high level
// - new program appears to fail while program fail bit set
// - protected block fail is 1 after aborted program or erase on a protected block
// - program paused bit 1 while program suspended, else 0
// - bank bit outside factory mode: 1 other bank busy or idle after factory mode exit until next command, 0 otherwise
// - factory mode word ready bit: 0 ready, 1 not ready or exited
// - supply fault sampled only at operation start, 1 below lockout
`timescale 1ns/1ps
`default_nettype none
module fsr_status
    import fsr_pkg::*;
#(
    parameter int SUSP_LAT_CYC = ERASE_SUSP_CYC // shorten in simulation
) (
    input  wire logic              sys_clk_i,       // 10 MHz clock
    input  wire logic              nrst_i,          // sync reset, low
    input  wire logic              ce_n_i,          // chip enable pin
    input  wire logic              oe_n_i,          // output enable pin
    input  wire logic [BANK_W-1:0] read_bank_i,     // bank of read address
    input  wire logic [DATA_W-1:0] array_data_i,    // array read data
    input  wire logic              read_status_i,   // read-status command
    input  wire logic              read_array_i,    // read-array command
    input  wire logic              clear_status_i,  // clear-status command
    input  wire logic              prog_start_i,    // program command
    input  wire logic              erase_start_i,   // erase command
    input  wire logic              blank_start_i,   // blank check command
    input  wire logic [BANK_W-1:0] op_bank_i,       // bank of new operation
    input  wire logic              block_locked_i,  // target block locked
    input  wire logic              supply_ok_i,     // supply above lockout
    input  wire logic              supply_high_i,   // supply at high level
    input  wire logic              op_done_i,       // algorithm finished
    input  wire logic              verify_fail_i,   // max pulses, no verify
    input  wire logic              overprog_i,      // one over zero attempt
    input  wire logic [DATA_W-1:0] blank_word_i,    // word read in check
    input  wire logic              blank_valid_i,   // blank_word_i valid
    input  wire logic              suspend_i,       // suspend command
    input  wire logic              resume_i,        // resume command
    input  wire logic              paused_i,        // algorithm has paused
    input  wire logic              buffered_factory_program_mode_i, // mode
    input  wire logic              word_ready_i,    // ready for buffer load
    output logic                   op_run_o,        // algorithm go
    output logic                   op_reject_o,     // command appears failed
    output logic                   pause_req_o,     // ask algorithm to pause
    output logic [DATA_W-1:0]      data_o,          // data bus out
    output logic                   data_oe_o        // data bus drive enable
);

    typedef enum {ST_IDLE, ST_PROG, ST_ERASE, ST_BLANK,
                  ST_SUSP_WAIT, ST_SUSPENDED} fsr_state_e;

    fsr_state_e         state_reg;
    fsr_state_e         susp_from_reg;
    logic [BANK_W-1:0]  bank_reg;
    logic               factory_exited_reg;
    logic               erase_fail_reg;
    logic               prog_fail_reg;
    logic               supply_reg;
    logic               prot_reg;
    logic               array_mode_reg;
    logic [2:0]         ce_sync_reg;
    logic [2:0]         oe_sync_reg;
    logic               ce_n_reg;
    logic               oe_n_reg;
    logic [7:0]         snap_reg;
    logic [15:0]        lat_cnt_reg;
    logic [7:0]         status_next;
    logic               busy;
    logic               any_start;
    logic               blocked;

    function automatic logic is_erased(input logic [DATA_W-1:0] w);
        return w == ERASED_WORD;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: change counts once stages two and three agree

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ce_sync_reg <= 3'b111;
            oe_sync_reg <= 3'b111;
            ce_n_reg    <= 1'b1;
            oe_n_reg    <= 1'b1;
        end else begin
            ce_sync_reg <= {ce_sync_reg[1:0], ce_n_i};
            oe_sync_reg <= {oe_sync_reg[1:0], oe_n_i};
            if (ce_sync_reg[1] == ce_sync_reg[2])
                ce_n_reg <= ce_sync_reg[2];
            if (oe_sync_reg[1] == oe_sync_reg[2])
                oe_n_reg <= oe_sync_reg[2];
        end
    end

    wire logic ce_now = (ce_sync_reg[1] == ce_sync_reg[2]) ? ce_sync_reg[2]
                                                           : ce_n_reg;
    wire logic oe_now = (oe_sync_reg[1] == oe_sync_reg[2]) ? oe_sync_reg[2]
                                                           : oe_n_reg;
    wire logic access_fall = (ce_n_reg & ~ce_now & ~oe_now)
                           | (oe_n_reg & ~oe_now & ~ce_now);
    wire logic access_on   = ~ce_now & ~oe_now;

    ////////////////////////////////////////////////////////////////////////
    // controller state

    assign busy      = (state_reg == ST_PROG) || (state_reg == ST_ERASE)
                    || (state_reg == ST_BLANK)
                    || (state_reg == ST_SUSP_WAIT);
    assign any_start = prog_start_i | erase_start_i | blank_start_i;
    // stale errors make the next command look failed; erase or program fail blocks only its own command
    assign blocked = (erase_start_i & erase_fail_reg)
                   | (prog_start_i & prog_fail_reg)
                   | supply_reg | prot_reg
                   | ~supply_ok_i | block_locked_i;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_reg     <= ST_IDLE;
            susp_from_reg <= ST_IDLE;
            bank_reg      <= '0;
            lat_cnt_reg   <= '0;
            op_run_o      <= 1'b0;
            op_reject_o   <= 1'b0;
            pause_req_o   <= 1'b0;
        end else begin
            op_reject_o <= 1'b0;
            case (state_reg)
            ST_IDLE: begin
                if (any_start && blocked) begin
                    op_reject_o <= 1'b1;
                end else if (any_start) begin
                    bank_reg  <= op_bank_i;
                    op_run_o  <= 1'b1;
                    state_reg <= prog_start_i  ? ST_PROG :
                                 erase_start_i ? ST_ERASE : ST_BLANK;
                end
            end
            ST_PROG, ST_ERASE, ST_BLANK: begin
                if (op_done_i) begin
                    op_run_o  <= 1'b0;
                    state_reg <= ST_IDLE;
                end else if (suspend_i && state_reg != ST_BLANK) begin
                    susp_from_reg <= state_reg;
                    pause_req_o   <= 1'b1;
                    lat_cnt_reg   <= '0;
                    state_reg     <= ST_SUSP_WAIT;
                end
            end
            ST_SUSP_WAIT: begin
                lat_cnt_reg <= lat_cnt_reg + 16'h0001;
                // finishing first wins over suspending
                if (op_done_i) begin
                    op_run_o    <= 1'b0;
                    pause_req_o <= 1'b0;
                    state_reg   <= ST_IDLE;
                end else if (paused_i ||
                        lat_cnt_reg >= 16'(SUSP_LAT_CYC - 1)) begin
                    state_reg <= ST_SUSPENDED;
                end
            end
            ST_SUSPENDED: begin
                if (resume_i) begin
                    pause_req_o <= 1'b0;
                    state_reg   <= susp_from_reg;
                end
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i)
            factory_exited_reg <= 1'b0;
        else if (buffered_factory_program_mode_i)
            factory_exited_reg <= 1'b1;
        else if (any_start)
            factory_exited_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky error bits: a set in the clear cycle wins

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            erase_fail_reg <= 1'b0;
            prog_fail_reg  <= 1'b0;
            supply_reg     <= 1'b0;
            prot_reg       <= 1'b0;
        end else begin
            if ((state_reg == ST_ERASE && verify_fail_i) ||
                (state_reg == ST_BLANK && blank_valid_i &&
                 !is_erased(blank_word_i)))
                erase_fail_reg <= 1'b1;
            else if (clear_status_i)
                erase_fail_reg <= 1'b0;
            if (state_reg == ST_PROG && (verify_fail_i ||
                (overprog_i && supply_high_i)))
                prog_fail_reg <= 1'b1;
            else if (clear_status_i)
                prog_fail_reg <= 1'b0;
            // supply checked only at operation start
            if (state_reg == ST_IDLE && any_start && !supply_ok_i)
                supply_reg <= 1'b1;
            else if (clear_status_i)
                supply_reg <= 1'b0;
            if (state_reg == ST_IDLE && (prog_start_i | erase_start_i)
                && block_locked_i)
                prot_reg <= 1'b1;
            else if (clear_status_i)
                prot_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status byte and read path

    always_comb begin
        status_next = 8'h00;
        status_next[BIT_IDLE] = !busy;
        status_next[BIT_ERASE_PAUSE] = (state_reg == ST_SUSPENDED) &&
                                       (susp_from_reg == ST_ERASE);
        status_next[BIT_ERASE_FAIL]  = erase_fail_reg;
        status_next[BIT_PROG_FAIL]   = prog_fail_reg;
        status_next[BIT_SUPPLY]      = supply_reg;
        status_next[BIT_PROG_PAUSE]  = (state_reg == ST_SUSPENDED) &&
                                       (susp_from_reg == ST_PROG);
        status_next[BIT_PROT_FAIL]   = prot_reg;
        if (buffered_factory_program_mode_i)
            status_next[BIT_BANK] = busy ? !word_ready_i : 1'b1;
        else if (factory_exited_reg && !busy)
            status_next[BIT_BANK] = 1'b1;
        else
            status_next[BIT_BANK] = busy &&
                                    (read_bank_i != bank_reg);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i)
            array_mode_reg <= 1'b1;
        else if (read_array_i)
            array_mode_reg <= 1'b1;
        else if (read_status_i || (state_reg == ST_IDLE && any_start))
            array_mode_reg <= 1'b0;
    end

    // snapshot frozen for the whole access, so a read never tears
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i)
            snap_reg <= STATUS_RESET;
        else if (access_fall)
            snap_reg <= status_next;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            data_o    <= '0;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= access_on;
            if (!array_mode_reg &&
                (!busy || read_bank_i == bank_reg || read_status_i))
                data_o <= {8'h00,
                           access_fall ? status_next : snap_reg};
            else
                data_o <= array_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_SNAP_HELD: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        access_on && !access_fall && $past(access_on) |=> $stable(snap_reg))
        else $error("snapshot changed during access");
    AST_IDLE_BIT: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        access_fall |=> snap_reg[BIT_IDLE] == !$past(busy))
        else $error("idle bit wrong in snapshot");
    AST_ERR_STICKY: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        erase_fail_reg && !clear_status_i |=> erase_fail_reg)
        else $error("erase fail cleared without command");
    AST_ERASE_REJ: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_IDLE && erase_start_i && erase_fail_reg
        |=> op_reject_o && state_reg == ST_IDLE)
        else $error("erase accepted with stale error");
    AST_PROG_REJ: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_IDLE && prog_start_i && prog_fail_reg
        |=> op_reject_o ##1 !op_reject_o)
        else $error("program accepted with stale error");
    AST_OVERPROG: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_PROG && overprog_i && !supply_high_i &&
        !verify_fail_i && !prog_fail_reg |=> !prog_fail_reg)
        else $error("over-program flagged at low supply");
    AST_SUSP_BOUND: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_SUSP_WAIT && !op_done_i && lat_cnt_reg ==
        16'(SUSP_LAT_CYC - 1) |=> state_reg == ST_SUSPENDED)
        else $error("suspend latency exceeded");
    AST_RESUME: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_SUSPENDED && resume_i |=> ##1
        !status_next[BIT_ERASE_PAUSE] && !status_next[BIT_PROG_PAUSE])
        else $error("paused bit stuck after resume");
    AST_UPPER_ZERO: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !array_mode_reg && !busy |=> data_o[15:8] == 8'h00)
        else $error("status upper byte not zero");
    AST_BLANK: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_BLANK && blank_valid_i && blank_word_i != ERASED_WORD
        |=> erase_fail_reg)
        else $error("blank check miss not flagged");
    AST_PROT_SET: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_IDLE && erase_start_i && block_locked_i
        |=> prot_reg && op_reject_o)
        else $error("locked block attempt not flagged");
    AST_SUPPLY_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg != ST_IDLE && !supply_reg |=> !supply_reg)
        else $error("supply fault set during an operation");
    AST_BANK_IDLE: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        !busy && !buffered_factory_program_mode_i && !factory_exited_reg
        |-> !status_next[BIT_BANK])
        else $error("bank bit set while idle");
    AST_PAUSE_BUSY: assert property (
        @(posedge sys_clk_i) disable iff (!nrst_i)
        state_reg == ST_SUSP_WAIT |-> !status_next[BIT_IDLE])
        else $error("idle bit set before pause");

endmodule
`default_nettype wire

// ---- test/fsr_host.sv ----
// host model that reads the flash data bus through the pins
`timescale 1ns/1ps
`default_nettype none
module fsr_host
    import fsr_pkg::*;
(
    input  wire logic              clk_i,     // bench clock
    input  wire logic              data_oe_i, // device drives the bus
    output logic                   ce_n_o,    // chip enable, low active
    output logic                   oe_n_o,    // output enable, low active
    output logic [BANK_W-1:0]      bank_o     // bank of read address
);
    initial begin
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        bank_o = '0;
    end

    // single read per access, never burst or page
    task automatic rd(input logic [BANK_W-1:0] b, output logic ok);
        int n;
        @(negedge clk_i);
        ce_n_o = 1'b0;
        oe_n_o = 1'b0;
        bank_o = b;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (!data_oe_i && n < 30);
        ok = data_oe_i;
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        // released address: inverse, so no stale value looks valid
        bank_o = ~b;
        // gap keeps every access a fresh single read
        repeat (4) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ---- test/fsr_status_tb.sv ----
// self-checking bench for the flash operation status register
`timescale 1ns/1ps
`default_nettype none
module fsr_status_tb
    import fsr_pkg::*;
;
    localparam int RS = 0, RA = 1, CL = 2, PG = 3, ER = 4, BL = 5;
    localparam int SU = 6, RE = 7, DN = 8, BV = 9, OV = 10;
    logic              sys_clk_i;
    logic              nrst_i;
    logic [10:0]       pls;
    logic [BANK_W-1:0] op_bank, rbank;
    logic [DATA_W-1:0] arr, bword, dout;
    logic              lock, sup_ok, sup_hi, vfail, paused, fmode, wrdy;
    logic              ce_n, oe_n, run, rej, preq, doe, run_q, doe_q;
    logic [DATA_W-1:0] rd_q[$];
    logic [1:0]        cmd_q[$];
    int                err_total, num_checks, cyc, seed;

    // long latency so the not-yet-paused window is visible
    fsr_status #(.SUSP_LAT_CYC(40)) u_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .read_bank_i(rbank), .array_data_i(arr),
        .read_status_i(pls[RS]), .read_array_i(pls[RA]),
        .clear_status_i(pls[CL]), .prog_start_i(pls[PG]),
        .erase_start_i(pls[ER]), .blank_start_i(pls[BL]),
        .op_bank_i(op_bank), .block_locked_i(lock),
        .supply_ok_i(sup_ok), .supply_high_i(sup_hi),
        .op_done_i(pls[DN]), .verify_fail_i(vfail),
        .overprog_i(pls[OV]), .blank_word_i(bword),
        .blank_valid_i(pls[BV]), .suspend_i(pls[SU]),
        .resume_i(pls[RE]), .paused_i(paused),
        .buffered_factory_program_mode_i(fmode),
        .word_ready_i(wrdy), .op_run_o(run), .op_reject_o(rej),
        .pause_req_o(preq), .data_o(dout), .data_oe_o(doe));
    fsr_host u_host (.clk_i(sys_clk_i), .data_oe_i(doe), .ce_n_o(ce_n),
        .oe_n_o(oe_n), .bank_o(rbank));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp_rd(input logic [DATA_W-1:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t read %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_cmd(input logic [1:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t cmd %h exp %h", $time, g, e);
        end
    endtask
    task automatic pul(input int k);
        @(negedge sys_clk_i);
        pls[k] = 1'b1;
        @(negedge sys_clk_i);
        pls[k] = 1'b0;
    endtask
    task automatic rd(input logic [DATA_W-1:0] e);
        logic got;
        rd_q.push_back(e);
        u_host.rd(op_bank, got);
        if (!got) begin
            err_total++;
            $display("BAD %0t no drive %h exp %h", $time, got, 1'b1);
        end
    endtask
    // e is {op_run_o rose, op_reject_o}
    task automatic cmd(input int k, input logic [1:0] e);
        op_bank = BANK_W'($random(seed));
        cmd_q.push_back(e);
        pul(k);
    endtask

    // monitor: answers arrive in order, oldest note first
    always @(negedge sys_clk_i) begin
        if (doe && !doe_q) begin
            cmp_rd(dout, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
        end
        if ((run && !run_q) || rej) begin
            cmp_cmd({run, rej},
                    cmd_q.size() > 0 ? cmd_q.pop_front() : 'x);
        end
        doe_q <= doe;
        run_q <= run;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 8000) begin
            err_total++;
            $display("BAD %0t timeout %h exp %h", $time, cyc, 0);
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 81;
        pls = '0;
        op_bank = '0;
        arr = '0;
        bword = 16'hFFFF;
        {lock, sup_hi, vfail, paused, fmode, wrdy} = '0;
        sup_ok = 1'b1;
        nrst_i = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        pul(RS);
        rd(16'h0080);
        arr = DATA_W'($random(seed));
        pul(RA);
        rd(arr);
        cmd(ER, 2'b10);
        rd(16'h0000);
        pul(SU);
        rd(16'h0000);
        paused = 1'b1;
        rd(16'h00C0);
        paused = 1'b0;
        pul(RE);
        rd(16'h0000);
        vfail = 1'b1;
        pul(DN);
        vfail = 1'b0;
        rd(16'h00A0);
        cmd(ER, 2'b01);
        // an erase error alone does not block a program
        cmd(PG, 2'b10);
        pul(DN);
        rd(16'h00A0);
        pul(CL);
        rd(16'h0080);
        // supply drops mid-run: sampled only at the start
        for (int i = 0; i < 3; i++) begin
            sup_hi = (i == 1);
            cmd(PG, 2'b10);
            sup_ok = 1'b0;
            pul(OV);
            vfail = (i == 2);
            pul(DN);
            vfail = 1'b0;
            sup_ok = 1'b1;
            rd(i > 0 ? 16'h0090 : 16'h0080);
            if (i > 0) begin
                cmd(PG, 2'b01);
            end
            pul(CL);
        end
        lock = 1'b1;
        cmd(ER, 2'b01);
        lock = 1'b0;
        rd(16'h0082);
        nrst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        pul(RS);
        rd(16'h0080);
        sup_ok = 1'b0;
        cmd(PG, 2'b01);
        sup_ok = 1'b1;
        rd(16'h0088);
        pul(CL);
        for (int i = 0; i < 2; i++) begin
            cmd(BL, 2'b10);
            bword = 16'hFFFF;
            pul(BV);
            if (i == 1) begin
                bword = DATA_W'($random(seed)) & 16'hFFFE;
            end
            pul(BV);
            pul(DN);
            rd(i > 0 ? 16'h00A0 : 16'h0080);
            pul(CL);
        end
        cmd(PG, 2'b10);
        pul(SU);
        paused = 1'b1;
        rd(16'h0084);
        paused = 1'b0;
        pul(RE);
        pul(DN);
        rd(16'h0080);
        fmode = 1'b1;
        wrdy = 1'b1;
        cmd(PG, 2'b10);
        rd(16'h0000);
        wrdy = 1'b0;
        rd(16'h0001);
        pul(DN);
        fmode = 1'b0;
        rd(16'h0081);
        cmd(PG, 2'b10);
        pul(DN);
        rd(16'h0080);
        repeat (4) @(negedge sys_clk_i);
        // every noted result must have shown up
        num_checks++;
        if (rd_q.size() + cmd_q.size() != 0) begin
            err_total++;
            $display("BAD %0t left %h exp %h", $time,
                     rd_q.size() + cmd_q.size(), 0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
